// ### plic_params.svh
// Constants for the indicator, error tally and interrupt control bank.
// Assumes a 20 MHz core clock, with management frames sampled from the MDC pin.
// Functional notes
// - Indicators use 3-bit function codes, seventh off on indicators one to three
// - Indicator three selector bits 11:9, reset off
// - Indicator two selector bits 8:6, reset off
// - Indicator one selector bits 5:3, reset speed
// - Indicator zero bits 2:0, activity, seventh shows link
// - 16-bit receive error tally counts in reduced mode
// - Interrupt pin driven when enabled, polarity selectable
// - Clear-on-read bit makes flag reads clear flags
// - Auto-clear bit clears flag when condition ends
// - Re-setup bit blocks write-one clear while condition
// - Bits 10:0 enable the eleven interrupt events
`ifndef PLIC_PARAMS_SVH
`define PLIC_PARAMS_SVH

// Register indices on the management bus
`define PLIC_REG_LED 5'h14
`define PLIC_REG_TALLY 5'h15
`define PLIC_REG_INTCTL 5'h16
`define PLIC_REG_FLAGS 5'h17

// Reset values
`define PLIC_LED_RST 12'hfe9
`define PLIC_TALLY_RST 16'h0000
`define PLIC_INTCTL_RST 16'h0000
`define PLIC_TALLY_MAX 16'hffff
`define PLIC_UNMAPPED_VAL 16'h0000

// Field positions of the interrupt control register
`define PLIC_INT_OE_BIT 15
`define PLIC_INT_RDCLR_BIT 14
`define PLIC_INT_POL_BIT 13
`define PLIC_INT_AUTO_BIT 12
`define PLIC_INT_RESETUP_BIT 11

// Indicator function codes
`define PLIC_FN_LINK 3'h0
`define PLIC_FN_ACT 3'h1
`define PLIC_FN_TX 3'h2
`define PLIC_FN_RX 3'h3
`define PLIC_FN_COL 3'h4
`define PLIC_FN_SPEED 3'h5
`define PLIC_FN_FDX 3'h6
`define PLIC_FN_OFF 3'h7

// Management frame bit counts
`define PLIC_PRE_LEN 6'h20
`define PLIC_HDR_LEN 6'h0d
`define PLIC_DATA_LEN 6'h10
`define PLIC_TA_LAST 6'h01

`endif

// ### plic_pkg.sv
// Types shared by the indicator and interrupt control bank.
// Assumes plic_params.svh supplies the numeric constants.
package plic_pkg;
    // Management frame receiver states
    typedef enum logic [2:0] {
        S_PRE,
        S_HDR,
        S_TA,
        S_RDATA,
        S_WDATA
    } plic_state_type;

    // Live link status feeding the indicator selectors
    typedef struct packed {
        logic link_up;
        logic activity;
        logic tx_data;
        logic rx_data;
        logic collision;
        logic speed_100;
        logic full_duplex;
    } plic_led_status_type;
endpackage

// ### plic_top.sv
// Indicator selectors, receive error tally and interrupt control, reached over MDC/MDIO.
// Assumes status, event and error inputs come from logic on I_CLK; MDC, MDIO and address straps are asynchronous.
`timescale 1ns/1ps
`include "plic_params.svh"

module plic_top
    import plic_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic I_MDC,
    input wire logic I_MDIO_I,
    output logic O_MDIO_O,
    output logic O_MDIO_OE,
    input wire logic [4:0] I_PHY_ADDR,
    input wire plic_led_status_type I_LED_STATUS,
    input wire logic I_RMII_MODE,
    input wire logic I_RX_ERR,
    input wire logic [10:0] I_EVENT_COND,
    output logic O_INDICATOR_OUT_ZERO,
    output logic O_INDICATOR_OUT_ONE,
    output logic O_INDICATOR_OUT_TWO,
    output logic O_INDICATOR_OUT_THREE,
    output logic O_INT_O,
    output logic O_INT_OE
);

    logic mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
    logic [4:0] addr_s1_q, addr_s2_q;
    logic mdc_rise;
    plic_state_type state_q, state_d;
    logic [5:0] cnt_q, cnt_d;
    logic [15:0] shift_q, shift_d;
    logic rd_q, rd_d;
    logic [4:0] reg_q, reg_d;
    logic mdio_o_q, mdio_o_d, mdio_oe_q, mdio_oe_d;
    logic wr_stb, rd_stb;
    logic [15:0] rd_val;
    logic [11:0] led_sel_q, led_sel_d;
    logic [15:0] tally_q, tally_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [10:0] flags_q, flags_d, cond_q, ev_set, ev_clr;
    logic [3:0] led_q, led_d;
    logic int_o_q, int_o_d, int_oe_q, int_oe_d, irq_any;

    // Two-stage synchronisers; the MDC edge is found on the second and third stages only
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            mdc_s1_q <= 1'b0;
            mdc_s2_q <= 1'b0;
            mdc_s3_q <= 1'b0;
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
            addr_s1_q <= 5'h00;
            addr_s2_q <= 5'h00;
        end else begin
            mdc_s1_q <= I_MDC;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            mdio_s1_q <= I_MDIO_I;
            mdio_s2_q <= mdio_s1_q;
            addr_s1_q <= I_PHY_ADDR;
            addr_s2_q <= addr_s1_q;
        end
    end

    // MDIO shares the MDC sync delay, so data is taken at the same rising edge
    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;

    // Register read mux; reserved bits and unmapped indices read as zero
    always_comb begin
        case (reg_q)
            `PLIC_REG_LED: rd_val = {4'h0, led_sel_q};
            `PLIC_REG_TALLY: rd_val = tally_q;
            `PLIC_REG_INTCTL: rd_val = ctrl_q;
            `PLIC_REG_FLAGS: rd_val = {5'h00, flags_q};
            default: rd_val = `PLIC_UNMAPPED_VAL;
        endcase
    end

    // Frame receiver: preamble, header, turnaround, then 16 data bits
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        rd_d = rd_q;
        reg_d = reg_q;
        mdio_o_d = mdio_o_q;
        mdio_oe_d = mdio_oe_q;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (mdc_rise) begin
            case (state_q)
                S_PRE: begin
                    if (mdio_s2_q) begin
                        cnt_d = (cnt_q == `PLIC_PRE_LEN) ? cnt_q : cnt_q + 6'h01;
                    end else begin
                        if (cnt_q == `PLIC_PRE_LEN) begin
                            state_d = S_HDR;
                        end
                        cnt_d = 6'h00;
                    end
                end
                S_HDR: begin
                    shift_d = {shift_q[14:0], mdio_s2_q};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == `PLIC_HDR_LEN - 6'h01) begin
                        reg_d = shift_d[4:0];
                        rd_d = (shift_d[11:10] == 2'b10);
                        cnt_d = 6'h00;
                        // Foreign addresses and bad start or opcode are ignored until the next preamble
                        if (shift_d[12] && (shift_d[11] != shift_d[10]) && (shift_d[9:5] == addr_s2_q)) begin
                            state_d = S_TA;
                        end else begin
                            state_d = S_PRE;
                        end
                    end
                end
                S_TA: begin
                    if (rd_q) begin
                        // Drive the turnaround zero and capture the word in one step
                        rd_stb = 1'b1;
                        shift_d = rd_val;
                        mdio_oe_d = 1'b1;
                        mdio_o_d = 1'b0;
                        state_d = S_RDATA;
                        cnt_d = 6'h00;
                    end else if (cnt_q == `PLIC_TA_LAST) begin
                        state_d = S_WDATA;
                        cnt_d = 6'h00;
                    end else begin
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                S_RDATA: begin
                    if (cnt_q == `PLIC_DATA_LEN) begin
                        mdio_oe_d = 1'b0;
                        mdio_o_d = 1'b0;
                        state_d = S_PRE;
                        cnt_d = 6'h00;
                    end else begin
                        mdio_o_d = shift_q[15];
                        shift_d = {shift_q[14:0], 1'b0};
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                S_WDATA: begin
                    shift_d = {shift_q[14:0], mdio_s2_q};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == `PLIC_DATA_LEN - 6'h01) begin
                        wr_stb = 1'b1;
                        state_d = S_PRE;
                        cnt_d = 6'h00;
                    end
                end
                default: begin
                    state_d = S_PRE;
                    cnt_d = 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            state_q <= S_PRE;
            cnt_q <= 6'h00;
            shift_q <= 16'h0000;
            rd_q <= 1'b0;
            reg_q <= 5'h00;
            mdio_o_q <= 1'b0;
            mdio_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            rd_q <= rd_d;
            reg_q <= reg_d;
            mdio_o_q <= mdio_o_d;
            mdio_oe_q <= mdio_oe_d;
        end
    end

    // One code table serves all four indicators; only indicator zero maps its last code to link
    function automatic logic led_pick(input logic [2:0] sel, input plic_led_status_type st, input logic is_zero);
        case (sel)
            `PLIC_FN_LINK: led_pick = st.link_up;
            `PLIC_FN_ACT: led_pick = st.activity;
            `PLIC_FN_TX: led_pick = st.tx_data;
            `PLIC_FN_RX: led_pick = st.rx_data;
            `PLIC_FN_COL: led_pick = st.collision;
            `PLIC_FN_SPEED: led_pick = st.speed_100;
            `PLIC_FN_FDX: led_pick = st.full_duplex;
            default: led_pick = is_zero & st.link_up;
        endcase
    endfunction

    // Writable registers, tally and indicator drive
    always_comb begin
        led_sel_d = led_sel_q;
        ctrl_d = ctrl_q;
        tally_d = tally_q;
        if (wr_stb && reg_q == `PLIC_REG_LED) begin
            led_sel_d = shift_d[11:0];
        end
        if (wr_stb && reg_q == `PLIC_REG_INTCTL) begin
            ctrl_d = shift_d;
        end
        if (wr_stb && reg_q == `PLIC_REG_TALLY) begin
            tally_d = shift_d;
        end else if (I_RMII_MODE && I_RX_ERR && tally_q != `PLIC_TALLY_MAX) begin
            tally_d = tally_q + 16'h0001;
        end
        led_d[0] = led_pick(led_sel_q[2:0], I_LED_STATUS, 1'b1);
        led_d[1] = led_pick(led_sel_q[5:3], I_LED_STATUS, 1'b0);
        led_d[2] = led_pick(led_sel_q[8:6], I_LED_STATUS, 1'b0);
        led_d[3] = led_pick(led_sel_q[11:9], I_LED_STATUS, 1'b0);
    end

    // Event flags: a new condition always wins over any clear in the same cycle
    always_comb begin
        ev_set = I_EVENT_COND & ~cond_q;
        ev_clr = 11'h000;
        if (wr_stb && reg_q == `PLIC_REG_FLAGS) begin
            ev_clr = shift_d[10:0] & (ctrl_q[`PLIC_INT_RESETUP_BIT] ? ~I_EVENT_COND : 11'h7ff);
        end
        if (rd_stb && reg_q == `PLIC_REG_FLAGS && ctrl_q[`PLIC_INT_RDCLR_BIT]) begin
            ev_clr = 11'h7ff;
        end
        if (ctrl_q[`PLIC_INT_AUTO_BIT]) begin
            ev_clr = ev_clr | ~I_EVENT_COND;
        end
        flags_d = (flags_q & ~ev_clr) | ev_set;
        irq_any = |(flags_q & ctrl_q[10:0]);
        int_o_d = ctrl_q[`PLIC_INT_POL_BIT] ? irq_any : ~irq_any;
        int_oe_d = ctrl_q[`PLIC_INT_OE_BIT];
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            led_sel_q <= `PLIC_LED_RST;
            tally_q <= `PLIC_TALLY_RST;
            ctrl_q <= `PLIC_INTCTL_RST;
            flags_q <= 11'h000;
            cond_q <= 11'h000;
            led_q <= 4'h0;
            int_o_q <= 1'b1;
            int_oe_q <= 1'b0;
        end else begin
            led_sel_q <= led_sel_d;
            tally_q <= tally_d;
            ctrl_q <= ctrl_d;
            flags_q <= flags_d;
            cond_q <= I_EVENT_COND;
            led_q <= led_d;
            int_o_q <= int_o_d;
            int_oe_q <= int_oe_d;
        end
    end

    // All outputs straight from flops
    assign O_MDIO_O = mdio_o_q;
    assign O_MDIO_OE = mdio_oe_q;
    assign O_INDICATOR_OUT_ZERO = led_q[0];
    assign O_INDICATOR_OUT_ONE = led_q[1];
    assign O_INDICATOR_OUT_TWO = led_q[2];
    assign O_INDICATOR_OUT_THREE = led_q[3];
    assign O_INT_O = int_o_q;
    assign O_INT_OE = int_oe_q;

    // Checks on defaults, indicators, tally and interrupt flags
    a_reset_defaults: assert property (@(posedge I_CLK) $rose(I_RESETN) |->
        (led_sel_q == `PLIC_LED_RST) && (ctrl_q == `PLIC_INTCTL_RST)) else $error("Bank defaults wrong after reset");
    a_ind_three_off: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (led_sel_q[11:9] == `PLIC_FN_OFF) && (led_sel_q[8:6] == `PLIC_FN_OFF) |=> !O_INDICATOR_OUT_THREE && !O_INDICATOR_OUT_TWO)
        else $error("Indicator lit while selected off");
    a_ind_one_speed: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (led_sel_q[5:3] == `PLIC_FN_SPEED) |=> O_INDICATOR_OUT_ONE == $past(I_LED_STATUS.speed_100))
        else $error("Indicator one does not follow speed");
    a_ind_zero_link: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (led_sel_q[2:0] == `PLIC_FN_OFF) |=> O_INDICATOR_OUT_ZERO == $past(I_LED_STATUS.link_up))
        else $error("Indicator zero seventh code not link status");
    a_tally_count: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        I_RMII_MODE && I_RX_ERR && !wr_stb && (tally_q != `PLIC_TALLY_MAX) |=> tally_q == $past(tally_q) + 16'h0001)
        else $error("Receive error not counted");
    a_int_pin_level: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        1'b1 |=> (O_INT_OE == $past(ctrl_q[15])) && (O_INT_O == ($past(irq_any) ~^ $past(ctrl_q[13]))))
        else $error("Interrupt pin enable or polarity wrong");
    a_read_clear: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        rd_stb && (reg_q == `PLIC_REG_FLAGS) && ctrl_q[14] |=> flags_q == $past(ev_set))
        else $error("Flags not cleared by read");
    a_read_keep: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        rd_stb && !ctrl_q[14] && !ctrl_q[12] |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("Flags lost on plain read");
    a_auto_clear: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        ctrl_q[12] |=> (flags_q & ~$past(I_EVENT_COND)) == 11'h000) else $error("Flag stayed after condition gone");
    a_resetup_keep: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        wr_stb && (reg_q == `PLIC_REG_FLAGS) && ctrl_q[11]
        |=> (flags_q & $past(flags_q & I_EVENT_COND)) == $past(flags_q & I_EVENT_COND))
        else $error("Flag cleared while condition present");
    a_flag_set_irq: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        |(I_EVENT_COND & ~cond_q & ctrl_q[10:0]) && ctrl_q[15] && (ctrl_d == ctrl_q)
        |=> ##1 O_INT_O == ctrl_q[13]) else $error("Enabled event did not raise pin");

endmodule

// ### plic_sta_model.sv
// Station manager model: drives MDC and MDIO frames toward the bank.
// Assumes the bench resolves the MDIO wire with a pull-up and feeds it back.
`timescale 1ns/1ps

module plic_sta_model #(
    parameter int HALF = 4
) (
    input wire logic i_clk,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_oe
);
    // MDC stands low and MDIO is released between frames
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end

    // One bit period: data set with MDC low, line sampled at the MDC rise
    task automatic bit_cycle(input logic b, input logic en, output logic s);
        @(posedge i_clk);
        o_mdc <= 1'b0;
        o_mdio <= b;
        o_mdio_oe <= en;
        repeat (HALF) @(posedge i_clk);
        s = i_mdio;
        o_mdc <= 1'b1;
        repeat (HALF - 1) @(posedge i_clk);
    endtask

    // Whole frame; on a read the line is released from the turnaround on
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [31:0] word;
        logic s;
        word = {2'b01, (rd ? 2'b10 : 2'b01), pa, ra, (rd ? 2'b11 : 2'b10), wd};
        q = 16'h0000;
        repeat (32) bit_cycle(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_cycle(word[i], !(rd && i < 18), s);
            if (i < 16) begin
                q[i] = s;
            end
        end
        @(posedge i_clk);
        o_mdc <= 1'b0;
        o_mdio_oe <= 1'b0;
        repeat (2 * HALF) @(posedge i_clk);
    endtask
endmodule

// ### plic_top_tb.sv
// Self-checking bench for the indicator, tally and interrupt bank.
// Assumes plic_sta_model carries every register access over MDC/MDIO.
`timescale 1ns/1ps
`include "plic_params.svh"

module plic_top_tb
    import plic_pkg::*;
;
    localparam logic [4:0] PHY = 5'h01;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mdc, mdio_m, mdio_m_oe, mdio_d, mdio_d_oe, mdio_w;
    plic_led_status_type led_st = '0;
    logic rmii = 1'b0;
    logic rx_err = 1'b0;
    logic [10:0] ev = 11'h000;
    logic ind_zero, ind_one, ind_two, ind_three, int_o, int_oe;
    logic [15:0] sel, q;
    logic [6:0] pat;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;

    // Pull-up on MDIO so a released line never holds a stale level
    assign mdio_w = mdio_d_oe ? mdio_d : (mdio_m_oe ? mdio_m : 1'b1);

    always #25 clk = ~clk;

    plic_top plic_top_i (
        .I_CLK(clk),
        .I_RESETN(rst_n),
        .I_MDC(mdc),
        .I_MDIO_I(mdio_w),
        .O_MDIO_O(mdio_d),
        .O_MDIO_OE(mdio_d_oe),
        .I_PHY_ADDR(PHY),
        .I_LED_STATUS(led_st),
        .I_RMII_MODE(rmii),
        .I_RX_ERR(rx_err),
        .I_EVENT_COND(ev),
        .O_INDICATOR_OUT_ZERO(ind_zero),
        .O_INDICATOR_OUT_ONE(ind_one),
        .O_INDICATOR_OUT_TWO(ind_two),
        .O_INDICATOR_OUT_THREE(ind_three),
        .O_INT_O(int_o),
        .O_INT_OE(int_oe)
    );

    plic_sta_model plic_sta_model_i (
        .i_clk(clk),
        .i_mdio(mdio_w),
        .o_mdc(mdc),
        .o_mdio(mdio_m),
        .o_mdio_oe(mdio_m_oe)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic wr(input logic [4:0] r, input logic [15:0] d);
        logic [15:0] x;
        plic_sta_model_i.frame(1'b0, PHY, r, d, x);
    endtask

    task automatic rd_chk(input logic [4:0] r, input logic [15:0] e);
        logic [15:0] x;
        plic_sta_model_i.frame(1'b1, PHY, r, 16'h0000, x);
        check(x, e);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk) rx_err <= 1'b1;
            @(posedge clk) rx_err <= 1'b0;
        end
    endtask

    task automatic set_ev(input logic [10:0] v);
        @(posedge clk) ev <= v;
    endtask

    // Interrupt pin enable and level after the pipeline settles; MDIO must be released between frames
    task automatic pin(input logic oe_e, input logic o_e);
        repeat (4) @(posedge clk);
        check({13'h0000, mdio_d_oe, int_oe, int_o}, {13'h0000, 1'b0, oe_e, o_e});
    endtask

    // Expected indicator level; code seven shows link only on indicator zero
    function automatic logic exp_led(input logic [2:0] c, input int k, input logic [6:0] st);
        if (c == 3'h7) begin
            return (k == 0) ? st[6] : 1'b0;
        end
        return st[6 - c];
    endfunction

    // Hang guard: the whole run needs about 23000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            conclude();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        pin(1'b0, 1'b1);
        rd_chk(`PLIC_REG_LED, 16'h0fe9);
        rd_chk(`PLIC_REG_TALLY, 16'h0000);
        rd_chk(`PLIC_REG_INTCTL, 16'h0000);
        rd_chk(5'h1f, 16'h0000);
        // Each indicator gets a different code so field positions matter
        for (int c = 0; c < 8; c++) begin
            sel = {4'h0, 3'(c + 3), 3'(c + 2), 3'(c + 1), 3'(c)};
            wr(`PLIC_REG_LED, sel);
            rd_chk(`PLIC_REG_LED, sel);
            for (int p = 0; p < 2; p++) begin
                pat = p ? 7'h2a : 7'h55;
                @(posedge clk) led_st <= plic_led_status_type'(pat);
                repeat (3) @(posedge clk);
                check({12'h000, ind_three, ind_two, ind_one, ind_zero}, {12'h000, exp_led(sel[11:9], 3, pat),
                      exp_led(sel[8:6], 2, pat), exp_led(sel[5:3], 1, pat), exp_led(sel[2:0], 0, pat)});
            end
        end
        // Tally counts only in reduced mode and saturates
        pulse(3);
        rd_chk(`PLIC_REG_TALLY, 16'h0000);
        @(posedge clk) rmii <= 1'b1;
        pulse(5);
        rd_chk(`PLIC_REG_TALLY, 16'h0005);
        wr(`PLIC_REG_TALLY, 16'hfffe);
        pulse(3);
        rd_chk(`PLIC_REG_TALLY, 16'hffff);
        plic_sta_model_i.frame(1'b0, 5'h02, `PLIC_REG_TALLY, 16'h1234, q);
        rd_chk(`PLIC_REG_TALLY, 16'hffff);
        // Active-low pin, flag sticks without auto clear or read clear
        wr(`PLIC_REG_INTCTL, 16'h8001);
        pin(1'b1, 1'b1);
        set_ev(11'h001);
        pin(1'b1, 1'b0);
        set_ev(11'h000);
        rd_chk(`PLIC_REG_FLAGS, 16'h0001);
        rd_chk(`PLIC_REG_FLAGS, 16'h0001);
        wr(`PLIC_REG_FLAGS, 16'h0001);
        pin(1'b1, 1'b1);
        // Active-high pin, a disabled event does not reach it
        wr(`PLIC_REG_INTCTL, 16'ha002);
        set_ev(11'h020);
        pin(1'b1, 1'b0);
        set_ev(11'h022);
        pin(1'b1, 1'b1);
        // Re-setup blocks the write-one clear while the condition holds
        wr(`PLIC_REG_INTCTL, 16'ha802);
        rd_chk(`PLIC_REG_INTCTL, 16'ha802);
        wr(`PLIC_REG_FLAGS, 16'h0002);
        rd_chk(`PLIC_REG_FLAGS, 16'h0022);
        set_ev(11'h020);
        wr(`PLIC_REG_FLAGS, 16'h0002);
        rd_chk(`PLIC_REG_FLAGS, 16'h0020);
        pin(1'b1, 1'b0);
        // Read clear, with the pin released
        wr(`PLIC_REG_INTCTL, 16'h4000);
        pin(1'b0, 1'b1);
        rd_chk(`PLIC_REG_FLAGS, 16'h0020);
        rd_chk(`PLIC_REG_FLAGS, 16'h0000);
        // Auto clear once the cause goes away
        wr(`PLIC_REG_INTCTL, 16'h1000);
        set_ev(11'h028);
        rd_chk(`PLIC_REG_FLAGS, 16'h0008);
        set_ev(11'h020);
        rd_chk(`PLIC_REG_FLAGS, 16'h0000);
        conclude();
    end
endmodule
